/* common/dco_cfg.svh */
// Purpose: Constants of the divided clock output block
// Assumes: Included by the package and by the design files
// Notes:   Counts are terminal values: a divide by N loads N minus one
`ifndef DCO_CFG_SVH
`define DCO_CFG_SVH

// ============================================================
// Divisor field
`define DCO_DIV_W        10
`define DCO_DIV_ZERO     10'h000
// Terminal count used on affected parts when a zero divisor was never preceded by a nonzero one
`define DCO_FIRST_ZERO_TERM 10'h01F
// Terminal count for a true divide by one
`define DCO_UNITY_TERM   10'h000

// ============================================================
// Source select encodings
`define DCO_SRC_SYS      1'h0
`define DCO_SRC_OSC      1'h1

// ============================================================
// Reset values
`define DCO_RST_SRC      1'h0
`define DCO_RST_OUT      1'h0

`endif

/* common/dco_pkg.sv */
// Purpose: Types of the divided clock output block
// Assumes: dco_cfg.svh supplies the widths
// Notes:   One setting travels as a packed struct from write to divider
`include "dco_cfg.svh"

package dco_pkg;

  // ============================================================
  // Setting carried from the configuration port to the divider
  typedef struct packed {
    logic                   src;
    logic [`DCO_DIV_W-1:0]  term;
  } dco_setting_t;

endpackage : dco_pkg

/* rtl/dco_tick_div.sv */
// Purpose: Counts source ticks and flags the wrap at a terminal count
// Assumes: tick_i is a one-cycle enable of the selected source
// Notes:   Terminal zero wraps on every tick
`include "dco_cfg.svh"

module dco_tick_div
  import dco_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  tick_i,
  input  wire logic [`DCO_DIV_W-1:0] term_i,
  output logic                       wrap_o
);

  logic [`DCO_DIV_W-1:0] cnt_r;

  // ============================================================
  // Counter
  always_comb begin
    wrap_o = tick_i && (cnt_r >= term_i);
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cnt_r <= `DCO_UNITY_TERM;
    end else if (wrap_o) begin
      cnt_r <= `DCO_UNITY_TERM;
    end else if (tick_i) begin
      cnt_r <= cnt_r + `DCO_DIV_W'(1);
    end
  end

endmodule : dco_tick_div

/* rtl/dco_top.sv */
// Purpose: Divided clock output: selects a source, divides it, drives the pin
// Assumes: Source ticks mark half periods of the source; one core clock
// Notes:   ERRATA_EN=1 reproduces the zero-divisor behaviour of affected parts
`include "dco_cfg.svh"

module dco_top
  import dco_pkg::*;
#(
  parameter bit ERRATA_EN = 1'b1
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  sys_tick_i,
  input  wire logic                  osc_tick_i,
  input  wire logic                  cfg_wr_i,
  input  wire logic                  cfg_src_i,
  input  wire logic [`DCO_DIV_W-1:0] cfg_div_i,
  output logic                       clk_pin_o,
  output logic                       cfg_pending_o
);

  // ============================================================
  // State
  dco_setting_t           pend_r;
  dco_setting_t           pend_nxt;
  logic                   pend_vld_r;
  dco_setting_t           act_r;
  logic                   written_nz_r;
  logic [`DCO_DIV_W-1:0]  last_nz_r;
  logic                   clk_out_r;
  logic                   src_tick;
  logic                   wrap;

  // ============================================================
  // Divisor field to terminal count
  function automatic logic [`DCO_DIV_W-1:0] eff_term(
    input logic [`DCO_DIV_W-1:0] div,
    input logic                  seen_nz,
    input logic [`DCO_DIV_W-1:0] prev_nz
  );
    logic [`DCO_DIV_W-1:0] t;
    t = div;
    if (div == `DCO_DIV_ZERO) begin
      if (!ERRATA_EN) begin
        t = `DCO_UNITY_TERM;
      end else if (seen_nz) begin
        t = prev_nz;
      end else begin
        t = `DCO_FIRST_ZERO_TERM;
      end
    end
    return t;
  endfunction : eff_term

  always_comb begin
    pend_nxt.src  = cfg_src_i;
    pend_nxt.term = eff_term(cfg_div_i, written_nz_r, last_nz_r);
  end

  // ============================================================
  // Divisor history, which the affected behaviour depends on
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      written_nz_r <= 1'b0;
      last_nz_r    <= `DCO_DIV_ZERO;
    end else if (cfg_wr_i && (cfg_div_i != `DCO_DIV_ZERO)) begin
      written_nz_r <= 1'b1;
      last_nz_r    <= cfg_div_i;
    end
  end

  // ============================================================
  // Pending setting: a later write before the wrap replaces an earlier one
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pend_r     <= '0;
      pend_vld_r <= 1'b0;
    end else if (cfg_wr_i) begin
      pend_r     <= pend_nxt;
      pend_vld_r <= 1'b1;
    end else if (wrap) begin
      pend_vld_r <= 1'b0;
    end
  end

  // ============================================================
  // Active setting; switching mid-period would give a runt pulse on the pin
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      act_r.src  <= `DCO_RST_SRC;
      act_r.term <= ERRATA_EN ? `DCO_FIRST_ZERO_TERM : `DCO_UNITY_TERM;
    end else if (wrap && pend_vld_r) begin
      act_r <= pend_r;
    end
  end

  // ============================================================
  // Source select and divider
  always_comb begin
    src_tick = (act_r.src == `DCO_SRC_OSC) ? osc_tick_i
                                           : sys_tick_i;
  end

  dco_tick_div u_div (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .tick_i     (src_tick),
    .term_i     (act_r.term),
    .wrap_o     (wrap)
  );

  // ============================================================
  // Pin driver: one toggle per wrap, so a period spans term+1 source periods
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      clk_out_r <= `DCO_RST_OUT;
    end else if (wrap) begin
      clk_out_r <= ~clk_out_r;
    end
  end

  always_comb begin
    clk_pin_o     = clk_out_r;
    cfg_pending_o = pend_vld_r;
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence nz_write_s;
    cfg_wr_i && (cfg_div_i != `DCO_DIV_ZERO);
  endsequence

  sequence zero_write_s;
    cfg_wr_i && (cfg_div_i == `DCO_DIV_ZERO);
  endsequence

  nz_divisor_a: assert property (
    nz_write_s |=> (pend_r.term == $past(cfg_div_i)) && pend_vld_r)
    else $error("nonzero divisor not taken as terminal count");

  zero_unity_a: assert property (
    (zero_write_s and (!ERRATA_EN)) |=> pend_r.term == `DCO_UNITY_TERM)
    else $error("zero divisor not divide by one");

  first_zero_a: assert property (
    (zero_write_s and (ERRATA_EN && !written_nz_r))
      |=> pend_r.term == `DCO_FIRST_ZERO_TERM)
    else $error("first zero divisor not divide by 32");

  keep_prev_a: assert property (
    (zero_write_s and (ERRATA_EN && written_nz_r))
      |=> pend_r.term == $past(last_nz_r))
    else $error("zero divisor did not keep previous divisor");

  osc_source_a: assert property (
    wrap && (act_r.src == `DCO_SRC_OSC) |-> osc_tick_i)
    else $error("divider advanced without oscillator tick");

  sys_source_a: assert property (
    wrap && (act_r.src == `DCO_SRC_SYS) |-> sys_tick_i)
    else $error("divider advanced without system tick");

  pin_toggle_a: assert property (
    wrap |=> clk_pin_o != $past(clk_pin_o))
    else $error("pin did not toggle at wrap");

  pin_hold_a: assert property (
    !wrap |=> $stable(clk_pin_o))
    else $error("pin changed without wrap");

  apply_wrap_a: assert property (
    !$stable(act_r) |-> $past(wrap) && $past(pend_vld_r))
    else $error("setting changed away from a wrap");

endmodule : dco_top

/* testbench/dco_pin_load.sv */
// Purpose: Pin load that measures the divided clock in source ticks
// Assumes: tick_i is the active source tick seen by the bench
// Notes:   period_o holds the tick count between the last two pin toggles
`include "dco_cfg.svh"

module dco_pin_load
  import dco_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       tick_i,
  input  wire logic       pin_i,
  output logic      [7:0] period_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       pin_q;
  logic [7:0] cnt;

  // ============================================================
  // Interval counter, restarted at every toggle of the pin
  always_ff @(posedge core_clk_i) begin
    pin_q <= pin_i;
    if (sys_rst_i) begin
      cnt      <= 8'h00;
      period_o <= 8'h00;
    end else if (pin_i != pin_q) begin
      period_o <= cnt;
      cnt      <= {7'h00, tick_i};
    end else begin
      cnt <= cnt + {7'h00, tick_i};
    end
  end
endmodule : dco_pin_load

/* testbench/dco_top_tb_top.sv */
// Purpose: Self-checking bench of the divided clock output, both silicon flavours
// Assumes: Pin loads measure toggle intervals in active source ticks
// Notes:   Instance 0 models affected parts, instance 1 corrected parts
`include "dco_cfg.svh"

module dco_top_tb_top
  import dco_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  core_clk_i, sys_rst_i, sys_tick_i, osc_tick_i;
  logic                  cfg_wr_i, cfg_src_i, cur_src;
  logic [`DCO_DIV_W-1:0] cfg_div_i;
  logic            [1:0] pin, pend;
  logic            [7:0] per [2];
  int                    n_fail, num_checks, seed, cyc, prev, i;
  logic           [31:0] r;
  wire                   act_tick = cur_src ? osc_tick_i : sys_tick_i;

  for (genvar g = 0; g < 2; g++) begin : g_u
    dco_top #(.ERRATA_EN(g == 0)) dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .sys_tick_i(sys_tick_i), .osc_tick_i(osc_tick_i), .cfg_wr_i(cfg_wr_i),
      .cfg_src_i(cfg_src_i), .cfg_div_i(cfg_div_i), .clk_pin_o(pin[g]),
      .cfg_pending_o(pend[g]));
    dco_pin_load u_load (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .tick_i(act_tick), .pin_i(pin[g]), .period_o(per[g]));
  end

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // ============================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // Expected ticks per toggle; a zero divisor depends on the silicon flavour
  function automatic int exp_div(input int d, input int p, input bit errata);
    return (d != 0) ? d + 1 : (errata ? p : 1);
  endfunction : exp_div

  // ============================================================
  // Stimulus: one active tick, the other source ticks at random
  task automatic pulse(input bit both);
    r = $random(seed);
    @(negedge core_clk_i);
    sys_tick_i = both | ~cur_src | r[0];
    osc_tick_i = both | cur_src | r[1];
    @(negedge core_clk_i);
    sys_tick_i = 1'b0;
    osc_tick_i = 1'b0;
    repeat (r[3:2]) @(negedge core_clk_i);
  endtask : pulse

  task automatic run(input logic s, input logic [`DCO_DIV_W-1:0] d, input bit wr);
    int k;
    int n0;
    int n1;
    if (wr) begin
      // Back-to-back writes: the second replaces the first as pending, but the first still sets the nonzero divisor history
      @(negedge core_clk_i);
      cfg_wr_i  = 1'b1;
      cfg_src_i = ~s;
      cfg_div_i = d + 10'h003;
      prev      = d + 4;
      @(negedge core_clk_i);
      cfg_src_i = s;
      cfg_div_i = d;
      @(negedge core_clk_i);
      cfg_wr_i = 1'b0;
      check(16'(pend), 16'h0003);
      k = 0;
      while (pend !== 2'b00 && k < 200) begin
        pulse(1'b1);
        k++;
      end
      check(16'(pend), 16'h0000);
      cur_src = s;
    end
    n0 = exp_div(d, prev, 1'b1);
    n1 = exp_div(d, prev, 1'b0);
    if (d != 0) prev = d + 1;
    repeat (3 * ((n0 > n1) ? n0 : n1) + 2) pulse(1'b0);
    repeat (2) @(negedge core_clk_i);
    check(16'(per[0]), 16'(n0));
    check(16'(per[1]), 16'(n1));
  endtask : run

  // ============================================================
  // Main sequence
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    {sys_tick_i, osc_tick_i, cfg_wr_i, cfg_src_i, cur_src} = 5'h00;
    cfg_div_i = 10'h000;
    seed      = 9;
    prev      = 32;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check(16'({pin, pend}), 16'h0000);
    sys_rst_i = 1'b0;
    // Zero as the very first write: affected parts must keep dividing by 32
    @(negedge core_clk_i);
    cfg_wr_i  = 1'b1;
    cfg_src_i = 1'b0;
    cfg_div_i = 10'h000;
    @(negedge core_clk_i);
    cfg_wr_i = 1'b0;
    check(16'(pend), 16'h0003);
    run(1'b0, 10'h000, 1'b0);
    run(1'b0, 10'h001, 1'b1);
    run(1'b0, 10'h000, 1'b1);
    run(1'b1, 10'h004, 1'b1);
    run(1'b1, 10'h000, 1'b1);
    // Nonzero divisor on the system source instead of a zero divisor
    run(1'b0, 10'h004, 1'b1);
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      run(r[4], {7'h00, r[7:5]}, 1'b1);
    end
    give_verdict();
  end
endmodule : dco_top_tb_top
